// *** rtl/ioca_pkg.sv ***
// Purpose: shared constants for io conditioning and alarms
// Assumes: 32-bit register words, word index addressing
// Notes: electrical values are in milli-units (mV or uA)
package ioca_pkg;
  localparam int AW = 5;
  localparam int DW = 32;
  localparam int NUM_ALM = 2;
  localparam int ALM_OC = 0;
  localparam int ALM_AUX = 1;
  // register word addresses
  localparam logic [4:0] A_AI_TYPE = 5'h00;
  localparam logic [4:0] A_OFFSET = 5'h01;
  localparam logic [4:0] A_RANGE_UPPER = 5'h02;
  localparam logic [4:0] A_RANGE_LOWER = 5'h03;
  localparam logic [4:0] A_MEAS = 5'h04;
  localparam logic [4:0] A_PV = 5'h05;
  localparam logic [4:0] A_ALM_DIS = 5'h06;
  localparam logic [4:0] A_ALM_DET = 5'h07;
  localparam logic [4:0] A_ALM_SIG = 5'h08;
  localparam logic [4:0] A_ALM_LAT = 5'h09;
  localparam logic [4:0] A_ALM_ACK = 5'h0a;
  localparam logic [4:0] A_ALM_STOP = 5'h0b;
  localparam logic [4:0] A_ALM_RELAY = 5'h0c;
  localparam logic [4:0] A_DI_TYPE = 5'h0d;
  localparam logic [4:0] A_DI_INVERT = 5'h0e;
  localparam logic [4:0] A_DI_STATUS = 5'h0f;
  localparam logic [4:0] A_RELAY = 5'h10;
  localparam logic [4:0] A_HW_CFG = 5'h11;
  localparam logic [4:0] A_LABEL0 = 5'h12;
  localparam logic [4:0] A_LABEL1 = 5'h13;
  // analog input type codes
  localparam logic [2:0] T_0_10V = 3'h0;
  localparam logic [2:0] T_1_5V = 3'h1;
  localparam logic [2:0] T_2_10V = 3'h2;
  localparam logic [2:0] T_0_5V = 3'h3;
  localparam logic [2:0] T_0_20MA = 3'h4;
  localparam logic [2:0] T_4_20MA = 3'h5;
  localparam logic signed [16:0] V0 = 17'sh00000;
  localparam logic signed [16:0] V1K = 17'sh003e8;
  localparam logic signed [16:0] V2K = 17'sh007d0;
  localparam logic signed [16:0] V4K = 17'sh00fa0;
  localparam logic signed [16:0] V5K = 17'sh01388;
  localparam logic signed [16:0] V10K = 17'sh02710;
  localparam logic signed [16:0] V20K = 17'sh04e20;
  localparam logic signed [16:0] OC_LIMIT = 17'sh061a8;
  localparam logic signed [15:0] OFFSET_MAX = 16'sh03e8;
  localparam logic signed [15:0] OFFSET_MIN = -16'sh03e8;
  // digital input type codes
  localparam logic [1:0] DI_VOLT = 2'h0;
  localparam logic [1:0] DI_CONTACT = 2'h1;
  localparam logic [1:0] DI_AUX = 2'h2;
  localparam int AUX_DI = 1;
  localparam int DI_MEAS_LSB = 8;
  localparam int DI_HEALTH_BIT = 16;
  // hardware config fields
  localparam int HW_NET_LSB = 0;
  localparam int HW_POW_LSB = 2;
  localparam int HW_PSU_BIT = 4;
  localparam int HW_TRES_BIT = 5;
  localparam int HW_BL_BIT = 6;
  // timing
  localparam int CLK_KHZ = 200000;
  localparam int TICK_FAST_MS = 100;
  localparam int TICK_SLOW_S = 6;
  localparam int TICK_FAST_CYC = TICK_FAST_MS * CLK_KHZ;
  localparam int TICK_SLOW_CYC = TICK_SLOW_S * 1000 * CLK_KHZ;
endpackage

// *** rtl/ioca_top.sv ***
// Purpose: analog/digital input conditioning, alarms, relay, hw config
// Assumes: adc_raw is sampled on clk; din, aux_fault are async pins
// Notes: register read data appear one cycle after rd_en
//
// Functional notes
// - analog input has six selectable range types
// - offset within plus/minus one added first
// - measured value is reading plus offset
// - process value scaled, clipped to range bounds
// - over 25 mA: alarm, force 0-10 V
// - every alarm has its own disable
// - detection flag shows condition present now
// - latched alarm holds signal until acknowledged
// - acknowledge clears the signaling flag
// - acknowledge ignored while detection still set
// - acknowledge self-clears, acts as one-shot
// - firing inhibit follows the alarm signal
// - alarm signal may drive the relay
// - digital type: voltage, contact, aux output (aux output on input 1 only)
// - digital state optionally inverted, reported
// - aux output health: 0 good, 1 bad
// - relay input reported; coil energized means off
// - read-only network type code from factory
// - timer resolution 100 ms or 6 s
// - backlight dimming off at 0, on at 1
// - supply rating code 24 V or 500 V
// - two home labels of three characters
`timescale 1ns/1ps
module ioca_top #(
  parameter int NUM_DI = 2,
  parameter int TICK_FAST = ioca_pkg::TICK_FAST_CYC,
  parameter int TICK_SLOW = ioca_pkg::TICK_SLOW_CYC
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic signed [15:0] adc_raw,
  input wire logic [NUM_DI-1:0] din,
  input wire logic aux_fault,
  input wire logic [1:0] net_type_strap,
  input wire logic [1:0] power_type_strap,
  input wire logic supply_strap,
  output logic ai_current_mode,
  output logic [NUM_DI-1:0] di_contact_mode,
  output logic aux_supply_output,
  output logic relay_coil,
  output logic firing_inhibit,
  output logic time_tick,
  output logic backlight_dim
);
  localparam int NA = ioca_pkg::NUM_ALM;

  logic [2:0] ai_type;
  logic signed [15:0] input_offset;
  logic signed [15:0] range_upper;
  logic signed [15:0] range_lower;
  logic signed [16:0] measured_value;
  logic signed [15:0] process_value;
  logic signed [16:0] span_min;
  logic signed [16:0] span_max;
  logic signed [15:0] next_pv;
  logic [NA-1:0] alm_dis, alm_det, alm_sig, alm_lat, alm_stop, alm_relay;
  logic [NA-1:0] alm_cond, alm_ack, next_det, next_sig;
  logic [2*NUM_DI-1:0] di_type;
  logic [NUM_DI-1:0] di_invert, di_state, di_pv;
  logic aux_state;
  logic oc_cond;
  logic relay_pv;
  logic [1:0] net_type, power_type;
  logic supply_rating, hw_cap, timer_res;
  logic [23:0] label0, label1;
  logic [31:0] tick_cnt;
  logic [31:0] rd_mux;
  logic wr_cfg;

  assign wr_cfg = wr_en && addr == ioca_pkg::A_HW_CFG;

  // span of each input type
  always_comb
  begin
    span_min = ioca_pkg::V0;
    span_max = ioca_pkg::V10K;
    case (ai_type)
      ioca_pkg::T_1_5V:
      begin
        span_min = ioca_pkg::V1K;
        span_max = ioca_pkg::V5K;
      end
      ioca_pkg::T_2_10V:
      begin
        span_min = ioca_pkg::V2K;
      end
      ioca_pkg::T_0_5V:
      begin
        span_max = ioca_pkg::V5K;
      end
      ioca_pkg::T_0_20MA:
      begin
        span_max = ioca_pkg::V20K;
      end
      ioca_pkg::T_4_20MA:
      begin
        span_min = ioca_pkg::V4K;
        span_max = ioca_pkg::V20K;
      end
      default:
      begin
        span_min = ioca_pkg::V0;
      end
    endcase
  end

  assign oc_cond = (ai_type == ioca_pkg::T_0_20MA || ai_type == ioca_pkg::T_4_20MA) &&
    17'(adc_raw) > ioca_pkg::OC_LIMIT;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ai_type <= ioca_pkg::T_0_10V;
    else if (oc_cond)
      ai_type <= ioca_pkg::T_0_10V;
    else if (wr_en && addr == ioca_pkg::A_AI_TYPE && wr_data[2:0] <= ioca_pkg::T_4_20MA)
      ai_type <= wr_data[2:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      input_offset <= 16'sh0000;
    else if (wr_en && addr == ioca_pkg::A_OFFSET)
    begin
      if ($signed(wr_data[15:0]) > ioca_pkg::OFFSET_MAX)
        input_offset <= ioca_pkg::OFFSET_MAX;
      else if ($signed(wr_data[15:0]) < ioca_pkg::OFFSET_MIN)
        input_offset <= ioca_pkg::OFFSET_MIN;
      else
        input_offset <= $signed(wr_data[15:0]);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      range_upper <= 16'sh0064;
      range_lower <= 16'sh0000;
    end
    else if (wr_en && addr == ioca_pkg::A_RANGE_UPPER)
      range_upper <= $signed(wr_data[15:0]);
    else if (wr_en && addr == ioca_pkg::A_RANGE_LOWER)
      range_lower <= $signed(wr_data[15:0]);
  end

  // linear scaling, clipped at the span ends
  always_comb
  begin
    logic signed [47:0] d48;
    logic signed [47:0] r48;
    logic signed [47:0] s48;
    d48 = 48'(measured_value) - 48'(span_min);
    r48 = 48'(range_upper) - 48'(range_lower);
    s48 = 48'(span_max) - 48'(span_min);
    if (measured_value >= span_max)
      next_pv = range_upper;
    else if (measured_value <= span_min)
      next_pv = range_lower;
    else
      next_pv = 16'(48'(range_lower) + d48 * r48 / s48);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      measured_value <= 17'sh00000;
      process_value <= 16'sh0000;
    end
    else
    begin
      measured_value <= 17'(adc_raw) + 17'(input_offset);
      process_value <= next_pv;
    end
  end

  // alarm path: disable, detect, signal, latch, acknowledge
  assign alm_cond[ioca_pkg::ALM_OC] = oc_cond;
  assign alm_cond[ioca_pkg::ALM_AUX] = aux_state && aux_supply_output;
  assign alm_ack = (wr_en && addr == ioca_pkg::A_ALM_ACK) ? wr_data[NA-1:0] : '0;
  assign next_det = alm_cond & ~alm_dis;
  // detection wins over acknowledge
  assign next_sig = next_det | (alm_lat & alm_sig & ~(alm_ack & ~alm_det));

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      alm_det <= '0;
      alm_sig <= '0;
    end
    else
    begin
      alm_det <= next_det;
      alm_sig <= next_sig;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      alm_dis <= '0;
      alm_lat <= '0;
      alm_stop <= '0;
      alm_relay <= '0;
    end
    else if (wr_en)
    begin
      if (addr == ioca_pkg::A_ALM_DIS)
        alm_dis <= wr_data[NA-1:0];
      if (addr == ioca_pkg::A_ALM_LAT)
        alm_lat <= wr_data[NA-1:0];
      if (addr == ioca_pkg::A_ALM_STOP)
        alm_stop <= wr_data[NA-1:0];
      if (addr == ioca_pkg::A_ALM_RELAY)
        alm_relay <= wr_data[NA-1:0];
    end
  end

  assign relay_pv = |(alm_sig & alm_relay);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      firing_inhibit <= 1'b0;
      relay_coil <= 1'b1;
    end
    else
    begin
      firing_inhibit <= |(alm_sig & alm_stop);
      relay_coil <= ~relay_pv;
    end
  end

  // pin synchronisers and filters; aux fault is the last bit
  genvar gi;
  generate
    for (gi = 0; gi <= NUM_DI; gi = gi + 1)
    begin : g_sync
      logic s1, s2, s3, filt;
      if (gi < NUM_DI)
      begin : g_di
        always_ff @(posedge clk)
          s1 <= din[gi];
        assign di_state[gi] = filt;
      end
      else
      begin : g_aux
        always_ff @(posedge clk)
          s1 <= aux_fault;
        assign aux_state = filt;
      end
      always_ff @(posedge clk)
      begin
        s2 <= s1;
        s3 <= s2;
        if (!rst_n)
          filt <= 1'b0;
        else if (s2 == s3)
          filt <= s3;
      end
    end
    for (gi = 0; gi < NUM_DI; gi = gi + 1)
    begin : g_di_pv
      assign di_pv[gi] = (di_type[2*gi +: 2] == ioca_pkg::DI_AUX) ? 1'b0 : di_state[gi] ^ di_invert[gi];
      always_ff @(posedge clk)
      begin
        if (!rst_n)
          di_contact_mode[gi] <= 1'b0;
        else
          di_contact_mode[gi] <= di_type[2*gi +: 2] == ioca_pkg::DI_CONTACT;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      di_type <= '0;
      di_invert <= '0;
      aux_supply_output <= 1'b0;
      ai_current_mode <= 1'b0;
    end
    else
    begin
      if (wr_en && addr == ioca_pkg::A_DI_TYPE)
        di_type <= wr_data[2*NUM_DI-1:0];
      if (wr_en && addr == ioca_pkg::A_DI_INVERT)
        di_invert <= wr_data[NUM_DI-1:0];
      aux_supply_output <= di_type[2*ioca_pkg::AUX_DI +: 2] == ioca_pkg::DI_AUX;
      ai_current_mode <= ai_type == ioca_pkg::T_0_20MA || ai_type == ioca_pkg::T_4_20MA;
    end
  end

  // straps caught once after reset release
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hw_cap <= 1'b0;
      net_type <= 2'h0;
      power_type <= 2'h0;
      supply_rating <= 1'b0;
    end
    else if (!hw_cap)
    begin
      hw_cap <= 1'b1;
      net_type <= net_type_strap;
      power_type <= power_type_strap;
      supply_rating <= supply_strap;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      timer_res <= 1'b0;
      backlight_dim <= 1'b0;
      label0 <= 24'h000000;
      label1 <= 24'h000000;
    end
    else
    begin
      if (wr_cfg)
      begin
        timer_res <= wr_data[ioca_pkg::HW_TRES_BIT];
        backlight_dim <= wr_data[ioca_pkg::HW_BL_BIT];
      end
      if (wr_en && addr == ioca_pkg::A_LABEL0)
        label0 <= wr_data[23:0];
      if (wr_en && addr == ioca_pkg::A_LABEL1)
        label1 <= wr_data[23:0];
    end
  end

  // time base tick
  always_ff @(posedge clk)
  begin
    if (!rst_n || wr_cfg)
    begin
      tick_cnt <= 32'h00000000;
      time_tick <= 1'b0;
    end
    else if (tick_cnt >= 32'((timer_res ? TICK_SLOW : TICK_FAST) - 1))
    begin
      tick_cnt <= 32'h00000000;
      time_tick <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 32'h00000001;
      time_tick <= 1'b0;
    end
  end

  always_comb
  begin
    rd_mux = 32'h00000000;
    case (addr)
      ioca_pkg::A_AI_TYPE: rd_mux = 32'(ai_type);
      ioca_pkg::A_OFFSET: rd_mux = 32'(input_offset);
      ioca_pkg::A_RANGE_UPPER: rd_mux = 32'(range_upper);
      ioca_pkg::A_RANGE_LOWER: rd_mux = 32'(range_lower);
      ioca_pkg::A_MEAS: rd_mux = 32'(measured_value);
      ioca_pkg::A_PV: rd_mux = 32'(process_value);
      ioca_pkg::A_ALM_DIS: rd_mux = 32'(alm_dis);
      ioca_pkg::A_ALM_DET: rd_mux = 32'(alm_det);
      ioca_pkg::A_ALM_SIG: rd_mux = 32'(alm_sig);
      ioca_pkg::A_ALM_LAT: rd_mux = 32'(alm_lat);
      ioca_pkg::A_ALM_STOP: rd_mux = 32'(alm_stop);
      ioca_pkg::A_ALM_RELAY: rd_mux = 32'(alm_relay);
      ioca_pkg::A_DI_TYPE: rd_mux = 32'(di_type);
      ioca_pkg::A_DI_INVERT: rd_mux = 32'(di_invert);
      ioca_pkg::A_DI_STATUS:
      begin
        rd_mux[NUM_DI-1:0] = di_pv;
        rd_mux[ioca_pkg::DI_MEAS_LSB +: NUM_DI] = di_state;
        rd_mux[ioca_pkg::DI_HEALTH_BIT] = aux_state && aux_supply_output;
      end
      ioca_pkg::A_RELAY: rd_mux = {30'h00000000, relay_coil, relay_pv};
      ioca_pkg::A_HW_CFG:
      begin
        rd_mux[ioca_pkg::HW_NET_LSB +: 2] = net_type;
        rd_mux[ioca_pkg::HW_POW_LSB +: 2] = power_type;
        rd_mux[ioca_pkg::HW_PSU_BIT] = supply_rating;
        rd_mux[ioca_pkg::HW_TRES_BIT] = timer_res;
        rd_mux[ioca_pkg::HW_BL_BIT] = backlight_dim;
      end
      ioca_pkg::A_LABEL0: rd_mux = 32'(label0);
      ioca_pkg::A_LABEL1: rd_mux = 32'(label1);
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || !rd_en)
      rd_data <= 32'h00000000;
    else
      rd_data <= rd_mux;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_oc_seen;
    oc_cond && !alm_dis[ioca_pkg::ALM_OC];
  endsequence
  sequence s_ack_blocked;
    (alm_ack & alm_det & alm_sig & alm_lat) != '0;
  endsequence

  a_oc_force_volt: assert property (oc_cond |=> ai_type == ioca_pkg::T_0_10V && !oc_cond)
    else $error("over-current did not force voltage mode");
  a_oc_detect: assert property (s_oc_seen |=> alm_det[ioca_pkg::ALM_OC] && alm_sig[ioca_pkg::ALM_OC])
    else $error("over-current not detected");
  a_ack_blocked: assert property (s_ack_blocked |=>
    (alm_sig & $past(alm_ack & alm_det & alm_lat)) == $past(alm_ack & alm_det & alm_lat))
    else $error("acknowledge cleared an active alarm");
  a_ack_clears: assert property ((alm_ack & ~alm_det & ~next_det) != '0 |=>
    (alm_sig & $past(alm_ack & ~alm_det & ~next_det)) == '0)
    else $error("acknowledge did not clear signal");
  a_latch_hold: assert property ((alm_lat & alm_sig & ~alm_ack) != '0 |=>
    (alm_sig & $past(alm_lat & alm_sig & ~alm_ack)) == $past(alm_lat & alm_sig & ~alm_ack))
    else $error("latched alarm lost");
  a_unlatched_follow: assert property (##1 ((alm_sig ^ alm_det) & ~$past(alm_lat)) == '0)
    else $error("unlatched signal differs from detection");
  a_dis_suppress: assert property (alm_dis != '0 |=> (alm_det & $past(alm_dis)) == '0)
    else $error("disabled alarm detected");
  a_inhibit_map: assert property (##1 firing_inhibit == |($past(alm_sig & alm_stop)))
    else $error("firing inhibit mismatch");
  a_relay_coil: assert property (##1 relay_coil == !(|($past(alm_sig & alm_relay))))
    else $error("relay coil mismatch");
  a_pv_clip_hi: assert property (measured_value >= span_max |=> process_value == $past(range_upper))
    else $error("process value not clipped high");
  a_pv_clip_lo: assert property (measured_value <= span_min |=> process_value == $past(range_lower))
    else $error("process value not clipped low");
  a_meas_offset: assert property (##1 measured_value == $past(17'(adc_raw) + 17'(input_offset)))
    else $error("measured value lacks offset");
  a_offset_bound: assert property (input_offset <= ioca_pkg::OFFSET_MAX && input_offset >= ioca_pkg::OFFSET_MIN)
    else $error("offset out of bounds");
endmodule

// *** bench/ioca_field_model.sv ***
// Purpose: field side of the block: analog sensor, contacts, aux load
// Assumes: bench sets sense level, contact states and a load short
// Notes: the aux pin reads high while the block drives it as an output
`timescale 1ns/1ps
module ioca_field_model (
  input wire logic signed [15:0] sense_level,
  input wire logic [1:0] contact_closed,
  input wire logic load_short,
  input wire logic aux_supply_output,
  output logic signed [15:0] adc_raw,
  output logic [1:0] din,
  output logic aux_fault
);
  assign adc_raw = sense_level;
  assign din[0] = contact_closed[0];
  // pin 1 carries the aux supply when enabled
  assign din[1] = aux_supply_output ? 1'b1 : contact_closed[1];
  // a short only loads the supply while it is on
  assign aux_fault = aux_supply_output & load_short;
endmodule

// *** bench/test_io_input_conditioning_alarms.sv ***
// Purpose: self-checking bench for io conditioning and alarms
// Assumes: reads scored from a queue one cycle after rd_en
// Notes: short tick counts (10 and 30) stand in for the real ones
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("MISMATCH %s expected %h seen %h", nm, e, g); \
    end \
  end
module test_io_input_conditioning_alarms;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data;
  logic signed [15:0] sense_level = 16'sh0000;
  logic [1:0] contact_closed = 2'h0;
  logic load_short = 1'b0;
  logic signed [15:0] adc_raw;
  logic [1:0] din;
  logic aux_fault;
  logic [1:0] net_s;
  logic [1:0] pow_s;
  logic sup_s;
  logic ai_current_mode;
  logic [1:0] di_contact_mode;
  logic aux_supply_output;
  logic relay_coil;
  logic firing_inhibit;
  logic time_tick;
  logic backlight_dim;
  int n_errors = 0;
  int num_checks = 0;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  logic [4:0] aq[$];
  logic rd_d = 1'b0;
  logic [31:0] m_e;
  logic [31:0] m_m;
  logic [4:0] m_a;
  int smin[6] = '{0, 1000, 2000, 0, 0, 4000};
  int smax[6] = '{10000, 5000, 10000, 5000, 20000, 20000};
  int adc;
  int off;
  int n;
  logic [1:0] c;
  logic [1:0] inv;

  always #2.5 clk = ~clk;

  ioca_top #(.NUM_DI(2), .TICK_FAST(10), .TICK_SLOW(30)) u_ioca_top (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .adc_raw(adc_raw), .din(din), .aux_fault(aux_fault),
    .net_type_strap(net_s), .power_type_strap(pow_s), .supply_strap(sup_s),
    .ai_current_mode(ai_current_mode), .di_contact_mode(di_contact_mode),
    .aux_supply_output(aux_supply_output), .relay_coil(relay_coil),
    .firing_inhibit(firing_inhibit), .time_tick(time_tick), .backlight_dim(backlight_dim)
  );

  ioca_field_model u_ioca_field_model (
    .sense_level(sense_level), .contact_closed(contact_closed), .load_short(load_short),
    .aux_supply_output(aux_supply_output), .adc_raw(adc_raw), .din(din), .aux_fault(aux_fault)
  );

  // read data stand only in the cycle after the strobe
  always @(posedge clk) rd_d <= rd_en;
  always @(negedge clk)
    if (rd_d)
    begin
      m_a = aq.pop_front();
      m_e = eq.pop_front();
      m_m = mq.pop_front();
      `CHK($sformatf("rd_data[%0h]", m_a), m_e, rd_data & m_m)
    end

  function automatic int exp_pv(input int m, input int t);
    if (m >= smax[t])
      return 1000;
    if (m <= smin[t])
      return -200;
    return -200 + (m - smin[t]) * 1200 / (smax[t] - smin[t]);
  endfunction

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    rd_en <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    @(posedge clk);
    addr <= a;
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    aq.push_back(a);
    eq.push_back(e & m);
    mq.push_back(m);
  endtask

  task automatic idle(input int k);
    repeat (k)
    begin
      @(posedge clk);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
    end
  endtask

  task automatic level(input int v, input int k);
    idle(1);
    sense_level <= 16'(v);
    idle(k);
  endtask

  // over-current burst while in a current type, then back to normal
  task automatic oc_pulse(input logic [31:0] t);
    wr(ioca_pkg::A_AI_TYPE, t);
    level(26000, 3);
    level(1000, 2);
  endtask

  task automatic tick_gap(output int g);
    int w;
    w = 0;
    while (time_tick !== 1'b1 && w < 100)
    begin
      @(negedge clk);
      w++;
    end
    @(negedge clk);
    g = 1;
    while (time_tick !== 1'b1 && g < 100)
    begin
      @(negedge clk);
      g++;
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("MISMATCH watchdog expected end seen timeout");
    complete_run();
  end

  initial
  begin
    void'($urandom(62362));
    @(posedge clk);
    net_s <= 2'($urandom_range(2));
    pow_s <= 2'($urandom_range(3));
    sup_s <= 1'($urandom_range(1));
    repeat (19) @(posedge clk);
    rst_n <= 1'b1;
    idle(2);
    rd(ioca_pkg::A_AI_TYPE, 32'h0);
    rd(ioca_pkg::A_RANGE_UPPER, 32'h64);
    rd(ioca_pkg::A_HW_CFG, {25'h0, 2'h0, sup_s, pow_s, net_s});
    rd(ioca_pkg::A_RELAY, 32'h2);
    rd(5'h1f, 32'h0);
    wr(ioca_pkg::A_LABEL0, 32'hffffffff);
    rd(ioca_pkg::A_LABEL0, 32'h00ffffff);
    wr(ioca_pkg::A_LABEL1, 32'h5a3c96e1);
    rd(ioca_pkg::A_LABEL1, 32'h003c96e1);
    @(negedge clk);
    `CHK("relay_coil", 1'b1, relay_coil)
    $display("test reset done");
    wr(ioca_pkg::A_RANGE_UPPER, 32'd1000);
    wr(ioca_pkg::A_RANGE_LOWER, 32'hffffff38);
    wr(ioca_pkg::A_AI_TYPE, 32'h6);
    rd(ioca_pkg::A_AI_TYPE, 32'h0);
    wr(ioca_pkg::A_OFFSET, 32'd5000);
    rd(ioca_pkg::A_OFFSET, 32'h3e8, 32'hffff);
    for (int t = 0; t < 6; t++)
    begin
      off = int'($urandom_range(2000)) - 1000;
      wr(ioca_pkg::A_AI_TYPE, 32'(t));
      wr(ioca_pkg::A_OFFSET, 32'(off));
      rd(ioca_pkg::A_AI_TYPE, 32'(t));
      for (int k = 0; k < 3; k++)
      begin
        adc = (k == 0) ? smin[t] + int'($urandom_range(smax[t] - smin[t])) : (k == 1) ? smax[t] + 500 : smin[t] - 500;
        level(adc, 4);
        rd(ioca_pkg::A_MEAS, 32'(adc + off));
        rd(ioca_pkg::A_PV, 32'(exp_pv(adc + off, t)));
      end
      @(negedge clk);
      `CHK("ai_current_mode", 1'(t >= 4), ai_current_mode)
    end
    $display("test analog done");
    level(0, 1);
    wr(ioca_pkg::A_ALM_LAT, 32'h3);
    wr(ioca_pkg::A_ALM_STOP, 32'h1);
    wr(ioca_pkg::A_ALM_RELAY, 32'h1);
    oc_pulse(32'h5);
    rd(ioca_pkg::A_AI_TYPE, 32'h0);
    rd(ioca_pkg::A_ALM_DET, 32'h0, 32'h1);
    rd(ioca_pkg::A_ALM_SIG, 32'h1, 32'h1);
    rd(ioca_pkg::A_RELAY, 32'h1);
    @(negedge clk);
    `CHK("firing_inhibit", 1'b1, firing_inhibit)
    `CHK("relay_coil", 1'b0, relay_coil)
    `CHK("ai_current_mode", 1'b0, ai_current_mode)
    wr(ioca_pkg::A_ALM_ACK, 32'h1);
    rd(ioca_pkg::A_ALM_SIG, 32'h0, 32'h1);
    rd(ioca_pkg::A_ALM_ACK, 32'h0);
    idle(2);
    @(negedge clk);
    `CHK("firing_inhibit", 1'b0, firing_inhibit)
    `CHK("relay_coil", 1'b1, relay_coil)
    wr(ioca_pkg::A_ALM_LAT, 32'h2);
    oc_pulse(32'h4);
    rd(ioca_pkg::A_ALM_SIG, 32'h0, 32'h1);
    rd(ioca_pkg::A_AI_TYPE, 32'h0);
    wr(ioca_pkg::A_ALM_LAT, 32'h3);
    wr(ioca_pkg::A_ALM_DIS, 32'h1);
    oc_pulse(32'h5);
    rd(ioca_pkg::A_ALM_SIG, 32'h0, 32'h1);
    rd(ioca_pkg::A_AI_TYPE, 32'h0);
    wr(ioca_pkg::A_ALM_DIS, 32'h0);
    wr(ioca_pkg::A_DI_TYPE, 32'h8);
    idle(1);
    load_short <= 1'b1;
    idle(10);
    rd(ioca_pkg::A_ALM_DET, 32'h2, 32'h2);
    rd(ioca_pkg::A_DI_STATUS, 32'h10000, 32'h10000);
    wr(ioca_pkg::A_ALM_ACK, 32'h2);
    rd(ioca_pkg::A_ALM_SIG, 32'h2, 32'h2);
    idle(1);
    load_short <= 1'b0;
    idle(10);
    rd(ioca_pkg::A_ALM_DET, 32'h0, 32'h2);
    rd(ioca_pkg::A_ALM_SIG, 32'h2, 32'h2);
    rd(ioca_pkg::A_DI_STATUS, 32'h0, 32'h10000);
    wr(ioca_pkg::A_ALM_ACK, 32'h2);
    rd(ioca_pkg::A_ALM_SIG, 32'h0, 32'h2);
    wr(ioca_pkg::A_ALM_DIS, 32'h2);
    idle(1);
    load_short <= 1'b1;
    idle(10);
    rd(ioca_pkg::A_ALM_DET, 32'h0, 32'h2);
    rd(ioca_pkg::A_ALM_SIG, 32'h0, 32'h2);
    @(negedge clk);
    `CHK("aux_supply_output", 1'b1, aux_supply_output)
    idle(1);
    load_short <= 1'b0;
    $display("test alarms done");
    wr(ioca_pkg::A_DI_TYPE, 32'h4);
    idle(2);
    @(negedge clk);
    `CHK("di_contact_mode", 2'b10, di_contact_mode)
    `CHK("aux_supply_output", 1'b0, aux_supply_output)
    for (int i = 0; i < 4; i++)
    begin
      inv = 2'(i);
      c = 2'($urandom_range(3));
      wr(ioca_pkg::A_DI_INVERT, 32'(inv));
      idle(1);
      contact_closed <= c;
      idle(8);
      rd(ioca_pkg::A_DI_STATUS, {22'h0, c, 6'h0, c ^ inv}, 32'h303);
    end
    $display("test digital done");
    wr(ioca_pkg::A_HW_CFG, 32'hffffffff);
    rd(ioca_pkg::A_HW_CFG, {25'h0, 2'h3, sup_s, pow_s, net_s});
    idle(2);
    @(negedge clk);
    `CHK("backlight_dim", 1'b1, backlight_dim)
    tick_gap(n);
    `CHK("tick period slow", 30, n)
    wr(ioca_pkg::A_HW_CFG, 32'h0);
    idle(2);
    @(negedge clk);
    `CHK("backlight_dim", 1'b0, backlight_dim)
    tick_gap(n);
    `CHK("tick period fast", 10, n)
    $display("test config done");
    idle(4);
    complete_run();
  end
endmodule
